// [cspsc_regs.vh]
// clock switch / power save controller: constants and field codes
// assumes inclusion by the controller, checker and bench files
//
// Contract
// RULE1 - switching and monitor only when config low
// RULE2 - disabled: ignore new select, report initial
// RULE3 - disabled: switch request held at zero
// RULE4 - software unlocks before each control write
// RULE5 - equal sources: clear request, abort switch
// RULE6 - valid switch clears lock and fail flags
// RULE7 - start target; wait timer or lock
// RULE8 - ten new-clock cycles before switch-over
// RULE9 - completion clears request, copies new select
// RULE10 - old source off, keep rc/crystal exceptions
// RULE11 - cpu keeps running during the switch
// RULE12 - no direct pll-to-pll switch, via fast rc; the sequencer does not block a pll-to-pll request
// RULE13 - primary submode fixed by configuration only
// RULE14 - monitor on keeps lowpower rc running
// RULE15 - failure raises trap, falls to fast rc
// RULE16 - pll fallback uses fast rc with pll
// RULE17 - sleep stops clock, monitor, clears watchdog
// RULE18 - wake on interrupt, reset, watchdog; same source
// RULE19 - idle halts cpu, clears watchdog, clock runs
// RULE20 - idle wake resumes two to four cycles
// RULE21 - coincident interrupt deferred until entry completes
// RULE22 - doze divides cpu clock only
// RULE23 - doze code n gives ratio two to n
// RULE24 - recover bit: interrupt clears doze
`ifndef CSPSC_REGS_VH
`define CSPSC_REGS_VH

// ****************************************
// oscillator source codes
// ****************************************
`define CSPSC_OSC_FRC      3'h0
`define CSPSC_OSC_FAST_RC_WITH_PLL   3'h1
`define CSPSC_OSC_PRI      3'h2
`define CSPSC_OSC_PRIPLL   3'h3
`define CSPSC_OSC_SOSC     3'h4
`define CSPSC_OSC_LOWPOWER_RC_OSC     3'h5

// ****************************************
// timing counts
// ****************************************
`define CSPSC_SETTLE_CYC   4'hA
`define CSPSC_WAKE_CYC     2'h2
`define CSPSC_DOZE_RST     3'h0

// ****************************************
// power save instruction operand
// ****************************************
`define CSPSC_PS_SLEEP     1'b0
`define CSPSC_PS_IDLE      1'b1

`endif

// [cspsc_doze_div.v]
// cpu clock enable divider for doze operation
// assumes a free running system clock and synchronous control
`timescale 1ns/1ps
`default_nettype none
`include "cspsc_regs.vh"

module cspsc_doze_div #(
  parameter CNT_W = 7
) (
  input  wire       sys_clk,
  input  wire       arst_n,
  input  wire       enable,
  input  wire [2:0] ratio_code,
  output reg        cpu_tick
);

  reg [CNT_W-1:0] count;

  // ****************************************
  // ratio decode
  // ****************************************
  // RULE23 power of two
  function [CNT_W-1:0] last_count;
    input [2:0] code;
    begin
      last_count = (({{(CNT_W-1){1'b0}}, 1'b1}) << code) - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // tick once per ratio; disabled means every cycle
  // RULE22 cpu only divided
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count    <= {CNT_W{1'b0}};
      cpu_tick <= 1'b1;
    end else if (!enable || count >= last_count(ratio_code)) begin
      count    <= {CNT_W{1'b0}};
      cpu_tick <= 1'b1;
    end else begin
      count    <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      cpu_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [cspsc_ctrl.v]
// clock switch sequencer, fail-safe fallback, sleep/idle and doze control
// assumes software unlock is checked before the write strobes arrive
// assumes oscillator ready/lock/fail indications are synchronous
`timescale 1ns/1ps
`default_nettype none
`include "cspsc_regs.vh"

module cspsc_ctrl (
  input  wire       sys_clk,
  input  wire       arst_n,
  // configuration
  input  wire       switch_monitor_cfg,
  input  wire [2:0] initial_osc_cfg,
  input  wire [1:0] primary_submode_cfg,
  input  wire       wdt_enable,
  // software writes (after unlock)
  input  wire       new_osc_wr,
  input  wire [2:0] new_osc_wdata,
  input  wire       switch_request_wr,
  input  wire       lowpower_crystal_keep,
  input  wire       clock_divider_reg_wr,
  input  wire       recover_on_interrupt_wdata,
  input  wire [2:0] doze_ratio_wdata,
  input  wire       cpu_slowdown_enable_wdata,
  // oscillator handshake
  input  wire       osc_ready,
  input  wire       pll_lock,
  input  wire       new_clk_tick,
  input  wire       osc_fail,
  // power save
  input  wire       power_save_instruction,
  input  wire       power_save_mode,
  input  wire       irq_pending,
  input  wire       wdt_timeout,
  // status and controls
  output reg  [2:0] new_osc_select,
  output reg  [2:0] current_osc_status,
  output reg        switch_request,
  output reg        pll_lock_flag,
  output reg        clock_fail_flag,
  output reg        clock_fail_trap,
  output reg  [5:0] osc_enable,
  output reg  [1:0] primary_submode,
  output reg        lowpower_rc_enable,
  output reg        sys_clk_run,
  output reg        cpu_run,
  output reg        cpu_clk_en,
  output reg        wdt_clear,
  output reg        periph_sys_enable,
  output reg        recover_on_interrupt,
  output reg        cpu_slowdown_enable,
  output reg  [2:0] doze_ratio
);

  // ****************************************
  // states
  // ****************************************
  localparam ST_IDLE    = 3'h0;
  localparam ST_WAITSRC = 3'h1;
  localparam ST_SETTLE  = 3'h2;
  localparam ST_SWITCH  = 3'h3;

  localparam PS_RUN   = 2'h0;
  localparam PS_SLEEP = 2'h1;
  localparam PS_IDLE  = 2'h2;
  localparam PS_WAKE  = 2'h3;

  reg [2:0] sw_state;
  reg [3:0] settle_cnt;
  reg [1:0] ps_state;
  reg [1:0] wake_cnt;
  reg       cfg_seen;
  reg [2:0] prev_osc;
  reg       osc_fail_q;
  wire      switch_en;
  wire      cpu_tick;

  // RULE1 config gate
  assign switch_en = ~switch_monitor_cfg;

  // ****************************************
  // helpers
  // ****************************************
  function is_pll;
    input [2:0] src;
    begin
      is_pll = (src == `CSPSC_OSC_FAST_RC_WITH_PLL) || (src == `CSPSC_OSC_PRIPLL);
    end
  endfunction

  function [5:0] onehot;
    input [2:0] src;
    begin
      onehot = 6'h01 << src;
    end
  endfunction

  // ****************************************
  // clock switch sequencer
  // ****************************************
  // the cpu is never stalled here; only software timing is at risk
  // RULE11 cpu unaffected
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_state           <= ST_IDLE;
      settle_cnt         <= 4'h0;
      new_osc_select     <= `CSPSC_OSC_FRC;
      current_osc_status <= `CSPSC_OSC_FRC;
      prev_osc           <= `CSPSC_OSC_FRC;
      switch_request     <= 1'b0;
      pll_lock_flag      <= 1'b0;
      clock_fail_flag    <= 1'b0;
      clock_fail_trap    <= 1'b0;
      cfg_seen           <= 1'b0;
      osc_fail_q         <= 1'b0;
      primary_submode    <= 2'h0;
    end else begin
      clock_fail_trap <= 1'b0;
      pll_lock_flag   <= pll_lock;
      // fail is a level; only its onset traps, so the trap stays one pulse
      osc_fail_q      <= osc_fail;
      // straps caught once after reset release
      // RULE13 submode from config
      if (!cfg_seen) begin
        cfg_seen           <= 1'b1;
        current_osc_status <= initial_osc_cfg;
        new_osc_select     <= initial_osc_cfg;
        primary_submode    <= primary_submode_cfg;
      end else if (!switch_en) begin
        // RULE2 report initial
        current_osc_status <= initial_osc_cfg;
        // RULE3 request held low
        switch_request     <= 1'b0;
        sw_state           <= ST_IDLE;
      end else if (osc_fail && !osc_fail_q && ps_state != PS_SLEEP) begin
        // RULE15 trap and fallback
        clock_fail_flag    <= 1'b1;
        clock_fail_trap    <= 1'b1;
        switch_request     <= 1'b0;
        sw_state           <= ST_IDLE;
        prev_osc           <= current_osc_status;
        // RULE16 keep pll scaling
        current_osc_status <= is_pll(current_osc_status) ?
                              `CSPSC_OSC_FAST_RC_WITH_PLL : `CSPSC_OSC_FRC;
      end else begin
        if (new_osc_wr && sw_state == ST_IDLE) begin
          new_osc_select <= new_osc_wdata;
        end
        case (sw_state)
          ST_IDLE: begin
            if (switch_request_wr) begin
              if (current_osc_status == new_osc_select) begin
                // RULE5 redundant abort
                switch_request <= 1'b0;
              end else begin
                switch_request  <= 1'b1;
                // RULE6 clear flags
                pll_lock_flag   <= 1'b0;
                clock_fail_flag <= 1'b0;
                sw_state        <= ST_WAITSRC;
              end
            end
          end
          ST_WAITSRC: begin
            // RULE7 wait ready or lock
            if (is_pll(new_osc_select) ? pll_lock : osc_ready) begin
              settle_cnt <= 4'h0;
              sw_state   <= ST_SETTLE;
            end
          end
          ST_SETTLE: begin
            // RULE8 ten new clocks
            if (new_clk_tick) begin
              if (settle_cnt == `CSPSC_SETTLE_CYC - 4'h1) begin
                sw_state <= ST_SWITCH;
              end else begin
                settle_cnt <= settle_cnt + 4'h1;
              end
            end
          end
          ST_SWITCH: begin
            // RULE9 report success
            switch_request     <= 1'b0;
            prev_osc           <= current_osc_status;
            current_osc_status <= new_osc_select;
            sw_state           <= ST_IDLE;
          end
          default: begin
            sw_state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // oscillator enables
  // ****************************************
  // target stays on while waiting; old source drops after switch
  // RULE10 old source off
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_enable         <= 6'h01;
      lowpower_rc_enable <= 1'b0;
    end else begin
      osc_enable <= (ps_state == PS_SLEEP) ? 6'h00 :
                    (onehot(current_osc_status) |
                     ((sw_state != ST_IDLE) ? onehot(new_osc_select) : 6'h00) |
                     (lowpower_crystal_keep ? onehot(`CSPSC_OSC_SOSC) : 6'h00));
      // RULE14 monitor keeps rc
      // RULE17 rc for watchdog
      lowpower_rc_enable <= wdt_enable ||
                            (switch_en && ps_state != PS_SLEEP);
    end
  end

  // ****************************************
  // sleep and idle
  // ****************************************
  // an interrupt seen with the instruction is only acted on after entry
  // RULE21 defer coincident interrupt
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ps_state          <= PS_RUN;
      wake_cnt          <= 2'h0;
      sys_clk_run       <= 1'b1;
      cpu_run           <= 1'b1;
      periph_sys_enable <= 1'b1;
      wdt_clear         <= 1'b0;
    end else begin
      wdt_clear <= 1'b0;
      case (ps_state)
        PS_RUN: begin
          if (power_save_instruction) begin
            // RULE17 clear watchdog
            // RULE19 clear watchdog
            wdt_clear <= 1'b1;
            cpu_run   <= 1'b0;
            if (power_save_mode == `CSPSC_PS_SLEEP) begin
              ps_state          <= PS_SLEEP;
              sys_clk_run       <= 1'b0;
              periph_sys_enable <= 1'b0;
            end else begin
              ps_state <= PS_IDLE;
            end
          end
        end
        PS_SLEEP, PS_IDLE: begin
          // RULE18 wake events
          if (irq_pending || wdt_timeout) begin
            // clock source unchanged, so sleep resumes on it
            sys_clk_run       <= 1'b1;
            periph_sys_enable <= 1'b1;
            wake_cnt          <= 2'h0;
            ps_state          <= PS_WAKE;
          end
        end
        PS_WAKE: begin
          // RULE20 resume delay
          if (wake_cnt == `CSPSC_WAKE_CYC - 2'h1) begin
            cpu_run  <= 1'b1;
            ps_state <= PS_RUN;
          end else begin
            wake_cnt <= wake_cnt + 2'h1;
          end
        end
        default: begin
          ps_state <= PS_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // doze control
  // ****************************************
  // clearing by an interrupt wins over a software write
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      recover_on_interrupt <= 1'b0;
      cpu_slowdown_enable  <= 1'b0;
      doze_ratio           <= `CSPSC_DOZE_RST;
    end else begin
      if (clock_divider_reg_wr) begin
        recover_on_interrupt <= recover_on_interrupt_wdata;
        doze_ratio           <= doze_ratio_wdata;
        cpu_slowdown_enable  <= cpu_slowdown_enable_wdata;
      end
      // RULE24 interrupt recovers speed
      if (recover_on_interrupt && irq_pending) begin
        cpu_slowdown_enable <= 1'b0;
      end
    end
  end

  cspsc_doze_div #(
    .CNT_W (7)
  ) u_doze (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .enable     (cpu_slowdown_enable),
    .ratio_code (doze_ratio),
    .cpu_tick   (cpu_tick)
  );

  // cpu clock gated by run state and doze tick
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clk_en <= 1'b0;
    end else begin
      cpu_clk_en <= cpu_tick && cpu_run && ps_state == PS_RUN;
    end
  end

endmodule
`default_nettype wire

// [cspsc_ctrl_properties.sv]
// port-level checker for the clock switch / power save controller
// assumes binding onto cspsc_ctrl, one clock domain on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "cspsc_regs.vh"

module cspsc_ctrl_props (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       switch_monitor_cfg,
  input wire logic       new_osc_wr,
  input wire logic       switch_request_wr,
  input wire logic       new_clk_tick,
  input wire logic       osc_fail,
  input wire logic       power_save_instruction,
  input wire logic       power_save_mode,
  input wire logic       irq_pending,
  input wire logic       wdt_timeout,
  input wire logic [2:0] new_osc_select,
  input wire logic [2:0] current_osc_status,
  input wire logic       switch_request,
  input wire logic       pll_lock_flag,
  input wire logic       clock_fail_flag,
  input wire logic       clock_fail_trap,
  input wire logic       sys_clk_run,
  input wire logic       cpu_run,
  input wire logic       wdt_clear,
  input wire logic       recover_on_interrupt,
  input wire logic       cpu_slowdown_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // ****************************************
  // helper logic
  // ****************************************
  logic [7:0] tk;
  logic       take;
  logic       done;
  // new-clock ticks seen while a switch is pending, saturating
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) tk <= 8'h00;
    else if (!switch_request) tk <= 8'h00;
    else if (new_clk_tick && tk != 8'hFF) tk <= tk + 8'h01;
  end
  // a request that the idle sequencer must act on
  assign take = switch_request_wr && !new_osc_wr && !switch_request && !switch_monitor_cfg
                && !osc_fail;

  // ****************************************
  // assertions
  // ****************************************
  // request held low
  a_disabled_req: assert property ($past(switch_monitor_cfg) && switch_monitor_cfg
    |-> !switch_request) else $error("request set while switching disabled");
  a_equal_abort: assert property (take && new_osc_select == current_osc_status
    |=> !switch_request) else $error("redundant switch not aborted");
  a_switch_start: assert property (take && new_osc_select != current_osc_status
    |=> switch_request && !pll_lock_flag && !clock_fail_flag) else $error("bad switch start");
  a_settle_ticks: assert property ($fell(switch_request) && !$past(osc_fail)
    && !$past(switch_monitor_cfg) |-> tk >= 8'h0A) else $error("switch before ten ticks");
  a_switch_done: assert property ($fell(switch_request) && !$past(osc_fail)
    && !$past(switch_monitor_cfg) |-> current_osc_status == new_osc_select)
    else $error("completed switch did not copy select");
  a_fail_trap: assert property ($rose(osc_fail) && !switch_monitor_cfg && sys_clk_run
    |=> clock_fail_trap && clock_fail_flag ##1 !clock_fail_trap) else $error("no fail trap");
  a_fail_pll: assert property ($rose(osc_fail) && !switch_monitor_cfg && sys_clk_run
    |=> current_osc_status == (($past(current_osc_status) == `CSPSC_OSC_PRIPLL
    || $past(current_osc_status) == `CSPSC_OSC_FAST_RC_WITH_PLL) ? `CSPSC_OSC_FAST_RC_WITH_PLL : `CSPSC_OSC_FRC))
    else $error("wrong fallback source");
  a_sleep_entry: assert property (power_save_instruction && cpu_run
    && power_save_mode == `CSPSC_PS_SLEEP |=> !sys_clk_run && !cpu_run && wdt_clear)
    else $error("bad sleep entry");
  a_idle_entry: assert property (power_save_instruction && cpu_run
    && power_save_mode == `CSPSC_PS_IDLE |=> sys_clk_run && !cpu_run && wdt_clear)
    else $error("bad idle entry");
  a_wake_bound: assert property (!cpu_run && (irq_pending || wdt_timeout)
    |-> ##[1:6] cpu_run) else $error("wake took too long");
  a_recover_doze: assert property (recover_on_interrupt && cpu_slowdown_enable
    && irq_pending |=> !cpu_slowdown_enable) else $error("doze not recovered");
endmodule
`default_nettype wire

// [cspsc_ctrl_bench.sv]
// self-checking bench for the clock switch / power save controller
// assumes cspsc_ctrl and its checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cspsc_regs.vh"

module cspsc_ctrl_bench;
  logic       sys_clk, arst_n, switch_monitor_cfg, wdt_enable, new_osc_wr, switch_request_wr;
  logic       lowpower_crystal_keep, clock_divider_reg_wr, recover_on_interrupt_wdata, osc_ready;
  logic       cpu_slowdown_enable_wdata, pll_lock, new_clk_tick, osc_fail, irq_pending;
  logic       power_save_instruction, power_save_mode, wdt_timeout;
  logic [2:0] initial_osc_cfg, new_osc_wdata, doze_ratio_wdata;
  logic [1:0] primary_submode_cfg;
  wire  [2:0] new_osc_select, current_osc_status, doze_ratio;
  wire  [5:0] osc_enable;
  wire  [1:0] primary_submode;
  wire        switch_request, pll_lock_flag, clock_fail_flag, clock_fail_trap, cpu_clk_en;
  wire        lowpower_rc_enable, sys_clk_run, cpu_run, wdt_clear, periph_sys_enable;
  wire        recover_on_interrupt, cpu_slowdown_enable;
  int         n_fail, checks_done, n;

  cspsc_ctrl cspsc_ctrl_i (.sys_clk, .arst_n, .switch_monitor_cfg, .initial_osc_cfg,
    .primary_submode_cfg, .wdt_enable, .new_osc_wr, .new_osc_wdata, .switch_request_wr,
    .lowpower_crystal_keep, .clock_divider_reg_wr, .recover_on_interrupt_wdata, .doze_ratio_wdata,
    .cpu_slowdown_enable_wdata, .osc_ready, .pll_lock, .new_clk_tick, .osc_fail,
    .power_save_instruction, .power_save_mode, .irq_pending, .wdt_timeout, .new_osc_select,
    .current_osc_status, .switch_request, .pll_lock_flag, .clock_fail_flag, .clock_fail_trap,
    .osc_enable, .primary_submode, .lowpower_rc_enable, .sys_clk_run, .cpu_run, .cpu_clk_en,
    .wdt_clear, .periph_sys_enable, .recover_on_interrupt, .cpu_slowdown_enable, .doze_ratio);

  // ****************************************
  // access tasks
  // ****************************************
  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic switch_to(input logic [2:0] src);
    @(posedge sys_clk) begin new_osc_wr <= 1'b1; new_osc_wdata <= src; end
    @(posedge sys_clk) new_osc_wr <= 1'b0;
    @(posedge sys_clk) switch_request_wr <= 1'b1;
    @(posedge sys_clk) switch_request_wr <= 1'b0;
    #1;
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge sys_clk) new_clk_tick <= 1'b1;
    @(posedge sys_clk) new_clk_tick <= 1'b0;
    st(2);
  endtask
  // idle entry also raises a coincident interrupt
  task automatic psave(input logic m);
    @(posedge sys_clk) begin
      power_save_instruction <= 1'b1;
      power_save_mode <= m;
      irq_pending <= m;
    end
    @(posedge sys_clk) power_save_instruction <= 1'b0;
    #1;
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {sys_clk, arst_n, new_osc_wr, switch_request_wr, clock_divider_reg_wr, osc_ready, pll_lock} = '0;
    {new_clk_tick, osc_fail, irq_pending, power_save_instruction, wdt_timeout} = '0;
    {recover_on_interrupt_wdata, cpu_slowdown_enable_wdata, power_save_mode} = '0;
    {new_osc_wdata, doze_ratio_wdata, wdt_enable, lowpower_crystal_keep} = '0;
    {switch_monitor_cfg, initial_osc_cfg, primary_submode_cfg} = {1'b1, 3'h2, 2'h1};
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    st(3);
    switch_to(`CSPSC_OSC_FRC);
    st(1);
    chk(switch_request, 1'b0);
    chk(current_osc_status, 3'h2);
    chk(lowpower_rc_enable, 1'b0);
    @(posedge sys_clk) begin switch_monitor_cfg <= 1'b0; osc_ready <= 1'b1; end
    switch_to(`CSPSC_OSC_PRI);
    chk(switch_request, 1'b0);
    switch_to(`CSPSC_OSC_FRC);
    chk({switch_request, pll_lock_flag, clock_fail_flag}, 3'h4);
    st(3);
    ticks(9);
    chk({switch_request, current_osc_status}, 4'hA);
    ticks(1);
    chk({switch_request, current_osc_status}, 4'h0);
    chk(osc_enable, 8'h01);
    chk(lowpower_rc_enable, 1'b1);
    switch_to(`CSPSC_OSC_PRIPLL);
    ticks(12);
    chk(switch_request, 1'b1);
    chk(osc_enable, 8'h09);
    chk(cpu_run, 1'b1);
    @(posedge sys_clk) pll_lock <= 1'b1;
    st(3);
    ticks(10);
    chk({switch_request, current_osc_status, primary_submode}, 6'h0D);
    @(posedge sys_clk) osc_fail <= 1'b1;
    st(2);
    chk({clock_fail_flag, current_osc_status}, 4'h9);
    @(posedge sys_clk) osc_fail <= 1'b0;
    psave(`CSPSC_PS_IDLE);
    chk({sys_clk_run, cpu_run}, 2'h2);
    st(6);
    chk(cpu_run, 1'b1);
    @(posedge sys_clk) irq_pending <= 1'b0;
    psave(`CSPSC_PS_SLEEP);
    chk({sys_clk_run, cpu_run}, 2'h0);
    st(1);
    chk({periph_sys_enable, lowpower_rc_enable, osc_enable}, 8'h00);
    @(posedge sys_clk) wdt_timeout <= 1'b1;
    st(6);
    chk({cpu_run, current_osc_status}, 4'h9);
    @(posedge sys_clk) wdt_timeout <= 1'b0;
    // cpu enables per window must follow the power-of-two ratio
    for (int c = 0; c < 8; c++) begin
      @(posedge sys_clk) begin
        clock_divider_reg_wr <= 1'b1;
        doze_ratio_wdata <= c[2:0];
        cpu_slowdown_enable_wdata <= 1'b1;
        recover_on_interrupt_wdata <= c[0];
      end
      @(posedge sys_clk) clock_divider_reg_wr <= 1'b0;
      st(4);
      n = 0;
      repeat (128) begin
        if (cpu_clk_en === 1'b1) n++;
        st(1);
      end
      chk(n[7:0], 8'h80 >> c);
    end
    @(posedge sys_clk) irq_pending <= 1'b1;
    st(2);
    chk({recover_on_interrupt, cpu_slowdown_enable, doze_ratio}, 8'h17);
    @(posedge sys_clk) irq_pending <= 1'b0;
    end_of_test;
  end

  // watchdog well past the expected run length
  initial begin
    repeat (6000) @(posedge sys_clk);
    n_fail++;
    end_of_test;
  end
endmodule

bind cspsc_ctrl cspsc_ctrl_props cspsc_ctrl_props_i (.sys_clk, .arst_n, .switch_monitor_cfg,
  .new_osc_wr, .switch_request_wr, .new_clk_tick, .osc_fail, .power_save_instruction,
  .power_save_mode, .irq_pending, .wdt_timeout, .new_osc_select, .current_osc_status,
  .switch_request, .pll_lock_flag, .clock_fail_flag, .clock_fail_trap, .sys_clk_run,
  .cpu_run, .wdt_clear, .recover_on_interrupt, .cpu_slowdown_enable);
`default_nettype wire
